// *** core/pi_ctrl_pkg.sv ***
package pi_ctrl_pkg;

  // register byte offsets
  localparam logic [7:0] CTRL_OFS     = 8'h00;
  localparam logic [7:0] STAT_OFS     = 8'h04;
  localparam logic [7:0] REF_OFS      = 8'h08;
  localparam logic [7:0] REFSCALE_OFS = 8'h0c;
  localparam logic [7:0] ACTSEL_OFS   = 8'h10;
  localparam logic [7:0] BUSACT_OFS   = 8'h14;
  localparam logic [7:0] ACTOFF_OFS   = 8'h18;
  localparam logic [7:0] ACTSCF_OFS   = 8'h1c;
  localparam logic [7:0] INV_OFS      = 8'h20;
  localparam logic [7:0] KP_OFS       = 8'h24;
  localparam logic [7:0] KPSCALE_OFS  = 8'h28;
  localparam logic [7:0] TN_OFS       = 8'h2c;
  localparam logic [7:0] OUTOFF_OFS   = 8'h30;
  localparam logic [7:0] LIMHI_OFS    = 8'h34;
  localparam logic [7:0] LIMLO_OFS    = 8'h38;
  localparam logic [7:0] STEEP0_OFS   = 8'h3c;
  localparam logic [7:0] STEEP1_OFS   = 8'h40;
  localparam logic [7:0] ROUTE_OFS    = 8'h44;
  localparam logic [7:0] INCREV_OFS   = 8'h48;
  localparam logic [7:0] RAW_OFS      = 8'h4c;
  localparam logic [7:0] FILT_OFS     = 8'h50;
  localparam logic [7:0] DIFF_OFS     = 8'h54;
  localparam logic [7:0] CV_OFS       = 8'h58;
  localparam logic [7:0] PROF_OFS     = 8'h5c;

  // field positions
  localparam int CTRL_ON_BIT    = 0;
  localparam int CTRL_RESETI_BIT = 1;
  localparam int SCALE_FRAC     = 8;

  // reset values
  localparam logic signed [15:0] SCALE_ONE_RST = 16'sh0100;
  localparam logic [15:0]        TN_RST        = 16'h2710;
  localparam logic signed [31:0] LIMHI_RST     = 32'sh00007fff;
  localparam logic signed [31:0] LIMLO_RST     = -32'sh00007fff;
  localparam logic [31:0]        INCREV_RST    = 32'h00010000;

  // timing
  localparam longint CLK_PERIOD_NS  = 10;
  localparam longint CYCLE_TIME_US  = 125;
  localparam longint CYCLE_CLKS     = (CYCLE_TIME_US * 1000) / CLK_PERIOD_NS;
  localparam logic [15:0] TN_OFF_MS = 16'h2710;

  // output routes
  typedef enum logic [2:0] {
    ROUTE_OFF, ROUTE_TORQUE, ROUTE_SPEED, ROUTE_POSITION, ROUTE_PROFILE
  } route_e;

  // actual value sources
  typedef struct packed {
    logic signed [31:0] analog0;
    logic signed [31:0] analog1;
    logic signed [31:0] speed_act;
    logic signed [31:0] pos_act;
    logic signed [31:0] speed_ref;
  } src_s;

  // additive references towards the drive loops
  typedef struct packed {
    logic signed [31:0] torque;
    logic signed [31:0] speed;
    logic signed [31:0] position;
    logic signed [31:0] profile_output_value;
  } route_s;

  typedef struct packed {
    logic [1:0]         loop_control_word;
    logic signed [31:0] process_reference_value;
    logic signed [15:0] reference_scale_factor;
    logic [2:0]         actual_source_select;
    logic signed [31:0] bus_actual_input;
    logic signed [31:0] actual_calibration_offset;
    logic [31:0]        actual_scale_and_filter_time;
    logic               difference_sign_invert;
    logic signed [15:0] proportional_gain;
    logic signed [15:0] gain_scaling;
    logic [15:0]        integral_time;
    logic signed [31:0] output_offset;
    logic signed [31:0] output_upper_limit;
    logic signed [31:0] output_lower_limit;
    logic [31:0]        steep0;
    logic [31:0]        steep1;
    route_e             output_route_select;
    logic [31:0]        increments_per_revolution;
    logic signed [31:0] raw_actual_value;
    logic signed [31:0] filter_state;
    logic signed [31:0] filtered_actual_value;
    logic signed [31:0] control_difference;
    logic signed [31:0] integ;
    logic signed [31:0] control_variable;
    logic               integral_reduced_flag;
    route_s             route;
    logic               wr;
    logic [7:0]         addr;
    logic [15:0]        div_cnt;
    logic               tick;
  } state_s;

endpackage

// *** core/process_pi_controller.sv ***
`timescale 1ns/1ns
// Notes on behaviour
// - each sample uses the latest reference value written by the bus
// - reference is multiplied by the reference scale factor
// - source select 2 takes the bus-written actual value as raw value
// - calibration offset is added to the selected raw actual value
// - first-order lag when filter time above 0 ms, then scaling
// - control difference sign is inverted when requested
// - loop runs only while control word bit 0 is 1
// - proportional gain multiplied by gain scaling acts on the difference
// - integral time of 10000 ms switches the integral term off
// - output offset added, then clamped between upper and lower limit
// - after clamp the change per sample is limited by steepness per ms
// - steepness 0 in normal run, steepness 1 ramps the integral down
// - steepness zero holds the control variable unchanged
// - route 0 off, 1 torque, 2 speed, 3 position addition
// - torque in Nm, speed in rpm, position in increments
// - profile route writes the control variable to the profile value
// - increments per revolution setting gives the position output unit
// - raw, filtered actual, difference and control variable are readable
// - one full computation in every speed-control sample cycle
// - status bit 1 reports the integral term has been reduced
module process_pi_controller #(
  parameter int CYCLE_CLKS = int'(pi_ctrl_pkg::CYCLE_CLKS)
) (
  // clock and reset
  input  wire logic                CLK,
  input  wire logic                RESET,
  // ahb-lite slave
  input  wire logic                HSEL,
  input  wire logic [31:0]         HADDR,
  input  wire logic [1:0]          HTRANS,
  input  wire logic                HWRITE,
  input  wire logic [2:0]          HSIZE,
  input  wire logic [31:0]         HWDATA,
  input  wire logic                HREADY,
  output      logic [31:0]         HRDATA,
  output      logic                HREADYOUT,
  output      logic                HRESP,
  // actual value sources
  input  wire pi_ctrl_pkg::src_s   SRC,
  // outputs to the drive loops
  output      pi_ctrl_pkg::route_s ROUTE,
  output      logic [31:0]         POS_INC_PER_REV,
  output      logic                SAMPLE_TICK
);

  pi_ctrl_pkg::state_s st;
  pi_ctrl_pkg::state_s next_st;

  logic signed [63:0] raw;
  logic signed [63:0] off;
  logic signed [63:0] filt;
  logic signed [63:0] act;
  logic signed [63:0] refs;
  logic signed [63:0] diff;
  logic signed [63:0] gain;
  logic signed [63:0] p;
  logic signed [63:0] inc;
  logic signed [63:0] integ;
  logic signed [63:0] u;
  logic signed [63:0] step0;
  logic signed [63:0] step1;
  logic signed [63:0] dlt;
  logic signed [63:0] tf;
  logic signed [63:0] cvn;
  logic               sat_hi;
  logic               sat_lo;
  logic               on;

  always_comb begin
    next_st = st;
    on = st.loop_control_word[pi_ctrl_pkg::CTRL_ON_BIT];
    // sample divider
    next_st.tick = 1'b0;
    if (st.div_cnt == 16'(CYCLE_CLKS - 1)) begin
      next_st.div_cnt = 16'h0000;
      next_st.tick = 1'b1;
    end else begin
      next_st.div_cnt = st.div_cnt + 16'h0001;
    end
    // bus address phase
    next_st.wr = 1'b0;
    if (HSEL && HTRANS[1] && HREADY) begin
      next_st.wr = HWRITE;
      next_st.addr = HADDR[7:0];
    end
    case (st.actual_source_select)
      3'h0: raw = 64'(SRC.analog0);
      3'h1: raw = 64'(SRC.analog1);
      3'h2: raw = 64'(st.bus_actual_input);
      3'h3: raw = 64'(SRC.speed_act);
      3'h4: raw = 64'(SRC.pos_act);
      3'h5: raw = 64'(SRC.speed_ref);
      default: raw = 64'sh0;
    endcase
    off = raw + 64'(st.actual_calibration_offset);
    tf = 64'(st.actual_scale_and_filter_time[15:0]) * 1000;
    if (tf == 64'sh0) begin
      filt = off;
    end else begin
      filt = 64'(st.filter_state) + ((off - 64'(st.filter_state)) * pi_ctrl_pkg::CYCLE_TIME_US)
             / (tf + pi_ctrl_pkg::CYCLE_TIME_US);
    end
    act = (filt * 64'($signed(st.actual_scale_and_filter_time[31:16]))) >>> pi_ctrl_pkg::SCALE_FRAC;
    // reference scaling, latest value each sample
    refs = (64'(st.process_reference_value) * 64'(st.reference_scale_factor)) >>> pi_ctrl_pkg::SCALE_FRAC;
    diff = st.difference_sign_invert ? act - refs : refs - act;
    gain = (64'(st.proportional_gain) * 64'(st.gain_scaling)) >>> pi_ctrl_pkg::SCALE_FRAC;
    p = (diff * gain) >>> pi_ctrl_pkg::SCALE_FRAC;
    inc = (p * pi_ctrl_pkg::CYCLE_TIME_US)
          / ((st.integral_time == 16'h0000 ? 64'sh1 : $signed(64'(st.integral_time))) * 1000);
    sat_hi = 64'(st.control_variable) >= 64'(st.output_upper_limit);
    sat_lo = 64'(st.control_variable) <= 64'(st.output_lower_limit);
    step0 = (64'(st.steep0) * pi_ctrl_pkg::CYCLE_TIME_US) / 1000;
    step1 = (64'(st.steep1) * pi_ctrl_pkg::CYCLE_TIME_US) / 1000;
    integ = 64'(st.integ);
    // ramped integral reduction with steepness 1
    if (st.loop_control_word[pi_ctrl_pkg::CTRL_RESETI_BIT]) begin
      if (integ > step1) begin
        integ = integ - step1;
      end else if (integ < -step1) begin
        integ = integ + step1;
      end else begin
        integ = 64'sh0;
      end
    end else if (st.integral_time >= pi_ctrl_pkg::TN_OFF_MS) begin
      integ = 64'sh0;
    end else if (!(sat_hi && inc > 0) && !(sat_lo && inc < 0)) begin
      integ = integ + inc;
    end
    u = p + integ + 64'(st.output_offset);
    if (u > 64'(st.output_upper_limit)) begin
      u = 64'(st.output_upper_limit);
    end
    if (u < 64'(st.output_lower_limit)) begin
      u = 64'(st.output_lower_limit);
    end
    dlt = u - 64'(st.control_variable);
    if (dlt > step0) begin
      dlt = step0;
    end
    if (dlt < -step0) begin
      dlt = -step0;
    end
    cvn = (st.steep0 == 32'h0) ? 64'(st.control_variable) : 64'(st.control_variable) + dlt;
    if (st.tick) begin
      next_st.raw_actual_value = 32'(raw);
      if (on) begin
        next_st.filter_state = 32'(filt);
        next_st.filtered_actual_value = 32'(act);
        next_st.control_difference = 32'(diff);
        next_st.integ = 32'(integ);
        next_st.control_variable = 32'(cvn);
      end else begin
        next_st.filter_state = 32'(off);
        next_st.integ = 32'sh0;
        next_st.control_variable = 32'sh0;
      end
    end
    next_st.integral_reduced_flag = st.loop_control_word[pi_ctrl_pkg::CTRL_RESETI_BIT] && st.integ == 32'sh0;
    // output routing, units follow the drive loops
    next_st.route.torque = st.output_route_select == pi_ctrl_pkg::ROUTE_TORQUE ? st.control_variable : 32'sh0;
    next_st.route.speed = st.output_route_select == pi_ctrl_pkg::ROUTE_SPEED ? st.control_variable : 32'sh0;
    next_st.route.position =
      st.output_route_select == pi_ctrl_pkg::ROUTE_POSITION ? st.control_variable : 32'sh0;
    if (st.output_route_select == pi_ctrl_pkg::ROUTE_PROFILE) begin
      next_st.route.profile_output_value = st.control_variable;
    end
    // bus data phase write
    if (st.wr) begin
      case (st.addr)
        pi_ctrl_pkg::CTRL_OFS:     next_st.loop_control_word = HWDATA[1:0];
        pi_ctrl_pkg::REF_OFS:      next_st.process_reference_value = HWDATA;
        pi_ctrl_pkg::REFSCALE_OFS: next_st.reference_scale_factor = HWDATA[15:0];
        pi_ctrl_pkg::ACTSEL_OFS:   next_st.actual_source_select = HWDATA[2:0];
        pi_ctrl_pkg::BUSACT_OFS:   next_st.bus_actual_input = HWDATA;
        pi_ctrl_pkg::ACTOFF_OFS:   next_st.actual_calibration_offset = HWDATA;
        pi_ctrl_pkg::ACTSCF_OFS:   next_st.actual_scale_and_filter_time = HWDATA;
        pi_ctrl_pkg::INV_OFS:      next_st.difference_sign_invert = HWDATA[0];
        pi_ctrl_pkg::KP_OFS:       next_st.proportional_gain = HWDATA[15:0];
        pi_ctrl_pkg::KPSCALE_OFS:  next_st.gain_scaling = HWDATA[15:0];
        pi_ctrl_pkg::TN_OFS:       next_st.integral_time = HWDATA[15:0];
        pi_ctrl_pkg::OUTOFF_OFS:   next_st.output_offset = HWDATA;
        pi_ctrl_pkg::LIMHI_OFS:    next_st.output_upper_limit = HWDATA;
        pi_ctrl_pkg::LIMLO_OFS:    next_st.output_lower_limit = HWDATA;
        pi_ctrl_pkg::STEEP0_OFS:   next_st.steep0 = HWDATA;
        pi_ctrl_pkg::STEEP1_OFS:   next_st.steep1 = HWDATA;
        pi_ctrl_pkg::ROUTE_OFS:    next_st.output_route_select = pi_ctrl_pkg::route_e'(HWDATA[2:0]);
        pi_ctrl_pkg::INCREV_OFS:   next_st.increments_per_revolution = HWDATA;
        default: ;
      endcase
    end
  end

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      st <= '0;
      st.reference_scale_factor <= pi_ctrl_pkg::SCALE_ONE_RST;
      st.actual_scale_and_filter_time <= {pi_ctrl_pkg::SCALE_ONE_RST, 16'h0000};
      st.proportional_gain <= pi_ctrl_pkg::SCALE_ONE_RST;
      st.gain_scaling <= pi_ctrl_pkg::SCALE_ONE_RST;
      st.integral_time <= pi_ctrl_pkg::TN_RST;
      st.output_upper_limit <= pi_ctrl_pkg::LIMHI_RST;
      st.output_lower_limit <= pi_ctrl_pkg::LIMLO_RST;
      st.increments_per_revolution <= pi_ctrl_pkg::INCREV_RST;
    end else begin
      st <= next_st;
    end
  end

  // register readback
  always_comb begin
    case (st.addr)
      pi_ctrl_pkg::CTRL_OFS:     HRDATA = {30'h0, st.loop_control_word};
      pi_ctrl_pkg::STAT_OFS:     HRDATA = {30'h0, st.integral_reduced_flag, st.loop_control_word[0]};
      pi_ctrl_pkg::REF_OFS:      HRDATA = st.process_reference_value;
      pi_ctrl_pkg::REFSCALE_OFS: HRDATA = {16'h0, st.reference_scale_factor};
      pi_ctrl_pkg::ACTSEL_OFS:   HRDATA = {29'h0, st.actual_source_select};
      pi_ctrl_pkg::BUSACT_OFS:   HRDATA = st.bus_actual_input;
      pi_ctrl_pkg::ACTOFF_OFS:   HRDATA = st.actual_calibration_offset;
      pi_ctrl_pkg::ACTSCF_OFS:   HRDATA = st.actual_scale_and_filter_time;
      pi_ctrl_pkg::INV_OFS:      HRDATA = {31'h0, st.difference_sign_invert};
      pi_ctrl_pkg::KP_OFS:       HRDATA = {16'h0, st.proportional_gain};
      pi_ctrl_pkg::KPSCALE_OFS:  HRDATA = {16'h0, st.gain_scaling};
      pi_ctrl_pkg::TN_OFS:       HRDATA = {16'h0, st.integral_time};
      pi_ctrl_pkg::OUTOFF_OFS:   HRDATA = st.output_offset;
      pi_ctrl_pkg::LIMHI_OFS:    HRDATA = st.output_upper_limit;
      pi_ctrl_pkg::LIMLO_OFS:    HRDATA = st.output_lower_limit;
      pi_ctrl_pkg::STEEP0_OFS:   HRDATA = st.steep0;
      pi_ctrl_pkg::STEEP1_OFS:   HRDATA = st.steep1;
      pi_ctrl_pkg::ROUTE_OFS:    HRDATA = {29'h0, st.output_route_select};
      pi_ctrl_pkg::INCREV_OFS:   HRDATA = st.increments_per_revolution;
      pi_ctrl_pkg::RAW_OFS:      HRDATA = st.raw_actual_value;
      pi_ctrl_pkg::FILT_OFS:     HRDATA = st.filtered_actual_value;
      pi_ctrl_pkg::DIFF_OFS:     HRDATA = st.control_difference;
      pi_ctrl_pkg::CV_OFS:       HRDATA = st.control_variable;
      pi_ctrl_pkg::PROF_OFS:     HRDATA = st.route.profile_output_value;
      default:                   HRDATA = 32'h0;
    endcase
  end

  assign HREADYOUT = 1'b1;
  assign HRESP = 1'b0;
  assign ROUTE = st.route;
  assign POS_INC_PER_REV = st.increments_per_revolution;
  assign SAMPLE_TICK = st.tick;

  default clocking cb @(posedge CLK); endclocking
  default disable iff (RESET);

  sequence ref_write_s;
    HSEL && HTRANS[1] && HWRITE && HREADY && HADDR[7:0] == pi_ctrl_pkg::REF_OFS;
  endsequence

  sequence data_phase_s;
    ##1 st.wr;
  endsequence

  ref_write_a: assert property (ref_write_s ##0 data_phase_s |=>
    st.process_reference_value == $past(HWDATA)) else $error("reference write not taken");

  tick_spacing_a: assert property (st.tick |=> !st.tick [*8])
    else $error("sample ticks too close");

  off_zero_a: assert property (st.tick && !on |=>
    st.control_variable == 32'sh0 && st.integ == 32'sh0) else $error("disabled loop not zero");

  hold_zero_a: assert property (st.tick && on && st.steep0 == 32'h0 |=>
    $stable(st.control_variable)) else $error("zero steepness changed output");

  integ_off_a: assert property (st.tick && on && st.integral_time == pi_ctrl_pkg::TN_OFF_MS
    && !st.loop_control_word[1] |=> st.integ == 32'sh0) else $error("integral not disabled");

  sign_inv_a: assert property (st.tick && on |=>
    st.control_difference == 32'($past(st.difference_sign_invert) ? $past(act - refs) : $past(refs - act)))
    else $error("difference sign wrong");

  route_off_a: assert property (st.output_route_select == pi_ctrl_pkg::ROUTE_OFF |=>
    st.route.torque == 32'sh0 && st.route.speed == 32'sh0 && st.route.position == 32'sh0)
    else $error("route off still drives");

  reduced_flag_a: assert property (st.integral_reduced_flag |->
    $past(st.integ) == 32'sh0) else $error("reduced flag with integral left");

  clamp_a: assert property (st.tick && on && st.output_upper_limit >= st.output_lower_limit |->
    u <= 64'(st.output_upper_limit) && u >= 64'(st.output_lower_limit)) else $error("clamp exceeded");

  sequence sample_on_s;
    st.tick && on;
  endsequence

  src_bus_a: assert property (sample_on_s ##0 st.actual_source_select == 3'h2 |=>
    st.raw_actual_value == $past(st.bus_actual_input))
    else $error("bus actual value not used");

  cal_offset_a: assert property (sample_on_s ##0 st.actual_scale_and_filter_time[15:0] == 16'h0000 |=>
    st.filter_state == $past(32'(raw + 64'(st.actual_calibration_offset))))
    else $error("calibration offset missing");

  step_limit_a: assert property (sample_on_s |=>
    64'(st.control_variable) - $past(64'(st.control_variable)) <= $past(step0) &&
    $past(64'(st.control_variable)) - 64'(st.control_variable) <= $past(step0))
    else $error("steepness exceeded");

  ramp_down_a: assert property (sample_on_s ##0 st.loop_control_word[1] |=>
    st.integ == 32'sh0 || 64'(st.integ) == $past(64'(st.integ)) - $past(step1) ||
    64'(st.integ) == $past(64'(st.integ)) + $past(step1))
    else $error("integral ramp wrong");

  windup_hi_a: assert property (sample_on_s ##0 sat_hi && !st.loop_control_word[1]
    && st.integral_time < pi_ctrl_pkg::TN_OFF_MS |=> st.integ <= $past(st.integ))
    else $error("integral grew at upper limit");

  windup_lo_a: assert property (sample_on_s ##0 sat_lo && !st.loop_control_word[1]
    && st.integral_time < pi_ctrl_pkg::TN_OFF_MS |=> st.integ >= $past(st.integ))
    else $error("integral fell at lower limit");

  route_torque_a: assert property (st.output_route_select == pi_ctrl_pkg::ROUTE_TORQUE |=>
    st.route.torque == $past(st.control_variable))
    else $error("torque route wrong");

  route_speed_a: assert property (st.output_route_select == pi_ctrl_pkg::ROUTE_SPEED |=>
    st.route.speed == $past(st.control_variable))
    else $error("speed route wrong");

  route_prof_a: assert property (st.output_route_select == pi_ctrl_pkg::ROUTE_PROFILE |=>
    st.route.profile_output_value == $past(st.control_variable))
    else $error("profile value wrong");

  raw_obs_a: assert property (st.tick |=>
    st.raw_actual_value == $past(32'(raw)))
    else $error("raw observation wrong");

endmodule // process_pi_controller

// *** testbench/drive_side_model.sv ***
`timescale 1ns/1ns
// far side: measured sources that feed the process loop
module drive_side_model (
  // sources towards the block
  output pi_ctrl_pkg::src_s SRC
);
  // distinct values so a wrong source pick shows
  assign SRC = '{analog0:   32'sh0000000b,
                 analog1:   32'sh00000016,
                 speed_act: 32'sh00000021,
                 pos_act:   32'sh0000002c,
                 speed_ref: 32'sh00000037};
endmodule // drive_side_model

// *** testbench/tb_process_pi_controller.sv ***
`timescale 1ns/1ns
module tb_process_pi_controller;
  localparam int CYC = 20;
  logic                clk;
  logic                reset;
  logic                hsel;
  logic                hwrite;
  logic                hreadyout;
  logic                hresp;
  logic                tick;
  logic [1:0]          htrans;
  logic [2:0]          hsize;
  logic [31:0]         haddr;
  logic [31:0]         hwdata;
  logic [31:0]         hrdata;
  logic [31:0]         increv;
  logic [31:0]         rd;
  pi_ctrl_pkg::src_s   src;
  pi_ctrl_pkg::route_s route;
  int                  bad_count = 0;
  int                  samples_checked = 0;
  int                  cycles = 0;

  process_pi_controller #(.CYCLE_CLKS(CYC)) u_process_pi_controller (
    .CLK(clk), .RESET(reset), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite),
    .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hreadyout), .HRDATA(hrdata), .HREADYOUT(hreadyout),
    .HRESP(hresp), .SRC(src), .ROUTE(route), .POS_INC_PER_REV(increv), .SAMPLE_TICK(tick));
  drive_side_model u_drive_side_model (.SRC(src));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // run ceiling
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      bad_count = bad_count + 1;
      conclude();
    end
  end

  task automatic conclude();
    $display("mismatches %0d comparisons %0d", bad_count, samples_checked);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic check32(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic check_route(input pi_ctrl_pkg::route_s got, input pi_ctrl_pkg::route_s exp);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // one single ahb-lite word transfer
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h000000, a};
    hwrite <= w;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    htrans <= 2'b00;
    hsel <= 1'b0;
    hwdata <= wd;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    rd = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] wd);
    xfer(1'b1, a, wd);
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h00000000);
    check32(rd, exp);
  endtask

  // wait for n computations to land
  task automatic samples(input int n);
    repeat (n) begin
      @(posedge clk);
      while (tick !== 1'b1) @(posedge clk);
    end
    repeat (3) @(posedge clk);
  endtask

  task automatic t_reset();
    rdchk(pi_ctrl_pkg::CTRL_OFS, 32'h00000000);
    rdchk(pi_ctrl_pkg::REFSCALE_OFS, 32'h00000100);
    rdchk(pi_ctrl_pkg::TN_OFS, 32'h00002710);
    rdchk(pi_ctrl_pkg::LIMHI_OFS, 32'h00007fff);
    rdchk(pi_ctrl_pkg::LIMLO_OFS, 32'hffff8001);
    rdchk(pi_ctrl_pkg::STEEP0_OFS, 32'h00000000);
    rdchk(pi_ctrl_pkg::ROUTE_OFS, 32'h00000000);
    rdchk(pi_ctrl_pkg::INCREV_OFS, 32'h00010000);
    check32(increv, 32'h00010000);
    wr(8'h60, 32'h12345678);
    rdchk(8'h60, 32'h00000000);
    wr(pi_ctrl_pkg::INCREV_OFS, 32'h00002000);
    rdchk(pi_ctrl_pkg::INCREV_OFS, 32'h00002000);
    check32(increv, 32'h00002000);
  endtask

  task automatic t_tick();
    int n;
    n = 0;
    @(posedge clk);
    while (tick !== 1'b1) @(posedge clk);
    do begin
      @(posedge clk);
      n++;
    end while (tick !== 1'b1);
    check32(n, CYC);
  endtask

  task automatic t_sources();
    logic [31:0] exp_raw [7] = '{32'h0b, 32'h16, 32'h64, 32'h21, 32'h2c, 32'h37, 32'h00};
    wr(pi_ctrl_pkg::KP_OFS, 32'h00000100);
    wr(pi_ctrl_pkg::KPSCALE_OFS, 32'h00000100);
    wr(pi_ctrl_pkg::ACTSCF_OFS, 32'h01000000);
    wr(pi_ctrl_pkg::STEEP0_OFS, 32'h00100000);
    wr(pi_ctrl_pkg::OUTOFF_OFS, 32'h0000000a);
    wr(pi_ctrl_pkg::BUSACT_OFS, 32'h00000064);
    wr(pi_ctrl_pkg::CTRL_OFS, 32'h00000001);
    for (int s = 0; s < 7; s++) begin
      wr(pi_ctrl_pkg::ACTSEL_OFS, s);
      samples(2);
      rdchk(pi_ctrl_pkg::RAW_OFS, exp_raw[s]);
    end
    rdchk(pi_ctrl_pkg::STAT_OFS, 32'h00000001);
    check_route(route, '0);
    wr(pi_ctrl_pkg::ACTSEL_OFS, 32'h00000002);
  endtask

  task automatic t_prop();
    wr(pi_ctrl_pkg::ACTOFF_OFS, 32'h00000005);
    wr(pi_ctrl_pkg::REF_OFS, 32'h0000012c);
    samples(2);
    rdchk(pi_ctrl_pkg::FILT_OFS, 32'h00000069);
    rdchk(pi_ctrl_pkg::DIFF_OFS, 32'h000000c3);
    rdchk(pi_ctrl_pkg::CV_OFS, 32'h000000cd);
    samples(2);
    rdchk(pi_ctrl_pkg::CV_OFS, 32'h000000cd);
  endtask

  task automatic t_invert();
    wr(pi_ctrl_pkg::INV_OFS, 32'h00000001);
    samples(2);
    rdchk(pi_ctrl_pkg::DIFF_OFS, 32'hffffff3d);
    rdchk(pi_ctrl_pkg::CV_OFS, 32'hffffff47);
    wr(pi_ctrl_pkg::INV_OFS, 32'h00000000);
  endtask

  task automatic t_clamp();
    wr(pi_ctrl_pkg::LIMHI_OFS, 32'h00000096);
    samples(2);
    rdchk(pi_ctrl_pkg::CV_OFS, 32'h00000096);
    wr(pi_ctrl_pkg::LIMHI_OFS, 32'h00007fff);
    wr(pi_ctrl_pkg::LIMLO_OFS, 32'h000000fa);
    samples(2);
    rdchk(pi_ctrl_pkg::CV_OFS, 32'h000000fa);
    wr(pi_ctrl_pkg::LIMLO_OFS, 32'hffff8001);
    samples(2);
    rdchk(pi_ctrl_pkg::CV_OFS, 32'h000000cd);
  endtask

  task automatic t_routes();
    pi_ctrl_pkg::route_s exp;
    for (int r = 1; r < 5; r++) begin
      wr(pi_ctrl_pkg::ROUTE_OFS, r);
      samples(2);
      exp = '0;
      case (r)
        1: exp.torque = 32'sh000000cd;
        2: exp.speed = 32'sh000000cd;
        3: exp.position = 32'sh000000cd;
        default: exp.profile_output_value = 32'sh000000cd;
      endcase
      check_route(route, exp);
    end
    rdchk(pi_ctrl_pkg::PROF_OFS, 32'h000000cd);
  endtask

  task automatic t_rate();
    wr(pi_ctrl_pkg::STEEP0_OFS, 32'h00000050);
    wr(pi_ctrl_pkg::REF_OFS, 32'h000003e8);
    samples(1);
    rdchk(pi_ctrl_pkg::CV_OFS, 32'h000000d7);
    samples(1);
    rdchk(pi_ctrl_pkg::CV_OFS, 32'h000000e1);
  endtask

  task automatic t_hold();
    logic [31:0] held;
    wr(pi_ctrl_pkg::STEEP0_OFS, 32'h00000000);
    xfer(1'b0, pi_ctrl_pkg::CV_OFS, 32'h00000000);
    held = rd;
    samples(2);
    rdchk(pi_ctrl_pkg::CV_OFS, held);
    wr(pi_ctrl_pkg::CTRL_OFS, 32'h00000003);
    samples(2);
    rdchk(pi_ctrl_pkg::STAT_OFS, 32'h00000003);
  endtask

  task automatic t_disable();
    wr(pi_ctrl_pkg::ROUTE_OFS, 32'h00000001);
    wr(pi_ctrl_pkg::CTRL_OFS, 32'h00000000);
    samples(2);
    rdchk(pi_ctrl_pkg::CV_OFS, 32'h00000000);
    rdchk(pi_ctrl_pkg::STAT_OFS, 32'h00000000);
    check32(route.torque, 32'h00000000);
  endtask

  initial begin
    reset = 1'b1;
    hsel = 1'b0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    haddr = 32'h00000000;
    hwdata = 32'h00000000;
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    t_reset();
    t_tick();
    t_sources();
    t_prop();
    t_invert();
    t_clamp();
    t_routes();
    t_rate();
    t_hold();
    t_disable();
    conclude();
  end
endmodule // tb_process_pi_controller
